/* File: common/bss_defines.vh */
// Constants for the buck set-point selection block.
// Assumes inclusion by bare name from the core files.
`ifndef BSS_DEFINES_VH
`define BSS_DEFINES_VH

// Register word addresses (index times four gives the byte address)
`define BSS_IDX_RUN      8'h35
`define BSS_IDX_STBY     8'h36
`define BSS_IDX_SLEEP    8'h37
`define BSS_IDX_MODE     8'h38
`define BSS_IDX_STATUS   8'h39
`define BSS_ADDR_W       10

// Field layout
`define BSS_SP_W         6
`define BSS_SP_MSB       5
`define BSS_RANGE_BIT    6
`define BSS_CODE_W       7
`define BSS_SP_RST       6'h00
`define BSS_RANGE_DFLT   1'b0

// Operating modes
`define BSS_MODE_W       2
`define BSS_MODE_RUN     2'h0
`define BSS_MODE_STBY    2'h1
`define BSS_MODE_SLEEP   2'h2

// Output voltages in millivolts
`define BSS_MV_W         12
`define BSS_LO_BASE_MV   12'h190
`define BSS_LO_STEP_MV   12'h019
`define BSS_HI_BASE_MV   12'h320
`define BSS_HI_STEP_MV   12'h032
`define BSS_MIN_OK_MV    12'h258

// Status word layout and the edge after release that catches the strap
`define BSS_STAT_MODE_LSB  8
`define BSS_STAT_UNSUP_BIT 16
`define BSS_RANGE_LATCH_AT 2'h2

// AXI responses
`define BSS_RESP_OKAY    2'h0
`define BSS_RESP_SLVERR  2'h2

`endif

/* File: core/bss_code_map.v */
// Maps a 7-bit target code to its output voltage in millivolts.
// Assumes code from logic on the same clock; result is registered.
`timescale 1ns/1ps
`default_nettype none
`include "bss_defines.vh"

module bss_code_map (
    input  wire                     core_clk_i,
    input  wire                     srst_i,
    input  wire [`BSS_CODE_W-1:0]   code_i,
    output reg  [`BSS_MV_W-1:0]     mv_o,
    output reg                      unsupported_o
);

    wire [`BSS_MV_W-1:0] step_w;
    wire [`BSS_MV_W-1:0] mv_w;

    assign step_w = {{(`BSS_MV_W-`BSS_SP_W){1'b0}}, code_i[`BSS_SP_MSB:0]};
    // Low range 25 mV steps from 400 mV, high range 50 mV from 800 mV
    assign mv_w = code_i[`BSS_RANGE_BIT] ?
        (`BSS_HI_BASE_MV + step_w * `BSS_HI_STEP_MV) :
        (`BSS_LO_BASE_MV + step_w * `BSS_LO_STEP_MV);

    always @(posedge core_clk_i) begin
        if (srst_i) begin
            mv_o          <= `BSS_LO_BASE_MV;
            unsupported_o <= 1'b1;
        end else begin
            mv_o          <= mv_w;
            // Flags codes software must avoid; 0.6 V or less
            unsupported_o <= (mv_w <= `BSS_MIN_OK_MV);
        end
    end

endmodule // bss_code_map

`default_nettype wire

/* File: core/bss_sp_bank.v */
// Small register bank holding the three set-point fields.
// Assumes one write port and one registered read port on core_clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "bss_defines.vh"

module bss_sp_bank (
    input  wire                     core_clk_i,
    input  wire                     srst_i,
    input  wire                     wr_en_i,
    input  wire [1:0]               wr_sel_i,
    input  wire [`BSS_SP_MSB:0]     wr_data_i,
    input  wire [1:0]               rd_sel_i,
    output reg  [`BSS_SP_MSB:0]     rd_data_o,
    output wire [3*`BSS_SP_W-1:0]   all_o
);

    reg [`BSS_SP_MSB:0] sp_q [0:2];
    genvar g;

    generate
        for (g = 0; g < 3; g = g + 1) begin : g_sp
            always @(posedge core_clk_i) begin
                if (srst_i) begin
                    sp_q[g] <= `BSS_SP_RST;
                end else if (wr_en_i && wr_sel_i == g) begin
                    sp_q[g] <= wr_data_i;
                end
            end
            assign all_o[g*`BSS_SP_W +: `BSS_SP_W] = sp_q[g];
        end
    endgenerate

    always @(posedge core_clk_i) begin
        if (srst_i) begin
            rd_data_o <= `BSS_SP_RST;
        end else if (rd_sel_i < 2'h3) begin
            rd_data_o <= sp_q[rd_sel_i];
        end else begin
            rd_data_o <= `BSS_SP_RST;
        end
    end

endmodule // bss_sp_bank

`default_nettype wire

/* File: core/bss_top.v */
// Set-point selection for one buck regulator, AXI4-Lite register slave.
// Assumes one 20 MHz clock, synchronous reset, range strap held stable.
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "bss_defines.vh"

module bss_top (
    input  wire                     core_clk_i,
    input  wire                     srst_i,
    input  wire                     range_strap_i,
    input  wire [`BSS_MODE_W-1:0]   mode_pin_i,
    input  wire                     mode_pin_en_i,
    input  wire [31:0]              s_axi_awaddr,
    input  wire                     s_axi_awvalid,
    output reg                      s_axi_awready,
    input  wire [31:0]              s_axi_wdata,
    input  wire [3:0]               s_axi_wstrb,
    input  wire                     s_axi_wvalid,
    output reg                      s_axi_wready,
    output reg  [1:0]               s_axi_bresp,
    output reg                      s_axi_bvalid,
    input  wire                     s_axi_bready,
    input  wire [31:0]              s_axi_araddr,
    input  wire                     s_axi_arvalid,
    output reg                      s_axi_arready,
    output reg  [31:0]              s_axi_rdata,
    output reg  [1:0]               s_axi_rresp,
    output reg                      s_axi_rvalid,
    input  wire                     s_axi_rready,
    output reg  [`BSS_CODE_W-1:0]   target_code_o,
    output reg  [`BSS_MV_W-1:0]     target_mv_o,
    output reg                      target_unsupported_o
);

    ////////////////////////////////////////////////////////////////////////
    // Address decode, shared by both bus channels
    localparam [2:0] SEL_RUN    = 3'h0;
    localparam [2:0] SEL_STBY   = 3'h1;
    localparam [2:0] SEL_SLEEP  = 3'h2;
    localparam [2:0] SEL_MODE   = 3'h3;
    localparam [2:0] SEL_STATUS = 3'h4;
    localparam [2:0] SEL_NONE   = 3'h7;

    function [2:0] dec;
        input [31:0] addr;
        begin
            if (addr[31:`BSS_ADDR_W] != 0 || addr[1:0] != 2'h0) begin
                dec = SEL_NONE;
            end else if (addr[`BSS_ADDR_W-1:2] == `BSS_IDX_RUN) begin
                dec = SEL_RUN;
            end else if (addr[`BSS_ADDR_W-1:2] == `BSS_IDX_STBY) begin
                dec = SEL_STBY;
            end else if (addr[`BSS_ADDR_W-1:2] == `BSS_IDX_SLEEP) begin
                dec = SEL_SLEEP;
            end else if (addr[`BSS_ADDR_W-1:2] == `BSS_IDX_MODE) begin
                dec = SEL_MODE;
            end else if (addr[`BSS_ADDR_W-1:2] == `BSS_IDX_STATUS) begin
                dec = SEL_STATUS;
            end else begin
                dec = SEL_NONE;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers for strap and mode pins
    reg                    strap_s1_q;
    reg                    strap_s2_q;
    reg [`BSS_MODE_W-1:0]  mpin_s1_q;
    reg [`BSS_MODE_W-1:0]  mpin_s2_q;
    reg                    men_s1_q;
    reg                    men_s2_q;
    reg [`BSS_MODE_W-1:0]  mpin_s3_q;
    reg [`BSS_MODE_W-1:0]  mpin_q;

    always @(posedge core_clk_i) begin
        strap_s1_q <= range_strap_i;
        strap_s2_q <= strap_s1_q;
        mpin_s1_q  <= mode_pin_i;
        mpin_s2_q  <= mpin_s1_q;
        mpin_s3_q  <= mpin_s2_q;
        men_s1_q   <= mode_pin_en_i;
        men_s2_q   <= men_s1_q;
    end

    // The two pin bits may land on different edges; a pin mode is only
    // taken once it reads the same twice, so no transient mode leaks out
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            mpin_q <= `BSS_MODE_RUN;
        end else if (mpin_s2_q == mpin_s3_q) begin
            mpin_q <= mpin_s3_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Range bit: caught once after reset release, then frozen
    reg range_q;
    reg range_cnt_q;
    reg [1:0] latch_cnt_q;

    // The strap needs two edges to reach the second stage after release
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            range_q     <= `BSS_RANGE_DFLT;
            latch_cnt_q <= 2'h0;
            range_cnt_q <= 1'b0;
        end else if (!range_cnt_q) begin
            latch_cnt_q <= latch_cnt_q + 2'h1;
            if (latch_cnt_q == `BSS_RANGE_LATCH_AT) begin
                range_q     <= strap_s2_q;
                range_cnt_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode register written by software, overridable by synced pins
    reg  [`BSS_MODE_W-1:0] mode_sw_q;
    wire [`BSS_MODE_W-1:0] mode_eff_w;

    assign mode_eff_w = men_s2_q ? mpin_q : mode_sw_q;

    ////////////////////////////////////////////////////////////////////////
    // Write channel: address and data accepted in either order
    reg        aw_held_q;
    reg        w_held_q;
    reg [31:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0]  w_strb_q;
    wire       aw_take_w;
    wire       w_take_w;
    wire       wr_go_w;
    wire [31:0] wr_addr_w;
    wire [31:0] wr_data_w;
    wire [3:0]  wr_strb_w;
    wire [2:0]  wr_sel_w;

    assign aw_take_w = s_axi_awvalid && s_axi_awready;
    assign w_take_w  = s_axi_wvalid && s_axi_wready;
    assign wr_addr_w = aw_held_q ? aw_addr_q : s_axi_awaddr;
    assign wr_data_w = w_held_q ? w_data_q : s_axi_wdata;
    assign wr_strb_w = w_held_q ? w_strb_q : s_axi_wstrb;
    assign wr_go_w   = (aw_held_q || aw_take_w) && (w_held_q || w_take_w);
    assign wr_sel_w  = dec(wr_addr_w);

    always @(posedge core_clk_i) begin
        if (srst_i) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `BSS_RESP_OKAY;
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            aw_addr_q     <= 32'h0000_0000;
            w_data_q      <= 32'h0000_0000;
            w_strb_q      <= 4'h0;
            mode_sw_q     <= `BSS_MODE_RUN;
        end else begin
            s_axi_awready <= !s_axi_bvalid && !aw_held_q && !aw_take_w;
            s_axi_wready  <= !s_axi_bvalid && !w_held_q && !w_take_w;
            if (aw_take_w && !wr_go_w) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_take_w && !wr_go_w) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_go_w) begin
                aw_held_q     <= 1'b0;
                w_held_q      <= 1'b0;
                s_axi_awready <= 1'b0;
                s_axi_wready  <= 1'b0;
                s_axi_bvalid  <= 1'b1;
                // Range bit writes are silently dropped, not an error
                s_axi_bresp   <= (wr_sel_w == SEL_NONE) ?
                                 `BSS_RESP_SLVERR : `BSS_RESP_OKAY;
                if (wr_sel_w == SEL_MODE && wr_strb_w[0]) begin
                    mode_sw_q <= wr_data_w[`BSS_MODE_W-1:0];
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= !aw_held_q;
                s_axi_wready  <= !w_held_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Set-point bank and read channel
    wire                   bank_wr_w;
    wire [`BSS_SP_MSB:0]   bank_rd_w;
    wire [3*`BSS_SP_W-1:0] bank_all_w;
    wire                   ar_take_w;
    wire [2:0]             ar_sel_w;
    wire [1:0]             rd_bank_sel_w;
    reg  [2:0]             rd_sel_q;
    reg                    rd_pend_q;

    // Only bits 5:0 are writable; bit 6 stays with the strap
    assign bank_wr_w = wr_go_w && wr_strb_w[0] &&
                       (wr_sel_w <= SEL_SLEEP);
    assign ar_take_w = s_axi_arvalid && s_axi_arready;
    assign ar_sel_w  = dec(s_axi_araddr);
    // Bank select goes out in the taking cycle, so its registered word
    // is already there on the edge that loads rdata
    assign rd_bank_sel_w = (ar_take_w && ar_sel_w <= SEL_SLEEP) ?
                           ar_sel_w[1:0] : 2'h0;

    bss_sp_bank u_bank (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .wr_en_i    (bank_wr_w),
        .wr_sel_i   (wr_sel_w[1:0]),
        .wr_data_i  (wr_data_w[`BSS_SP_MSB:0]),
        .rd_sel_i   (rd_bank_sel_w),
        .rd_data_o  (bank_rd_w),
        .all_o      (bank_all_w)
    );

    // Answer stands two edges after the address is taken
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `BSS_RESP_OKAY;
            rd_sel_q      <= SEL_NONE;
            rd_pend_q     <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !rd_pend_q && !s_axi_arready;
            if (ar_take_w) begin
                s_axi_arready <= 1'b0;
                rd_sel_q      <= ar_sel_w;
                rd_pend_q     <= 1'b1;
            end else if (rd_pend_q) begin
                rd_pend_q    <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `BSS_RESP_OKAY;
                s_axi_rdata  <= 32'h0000_0000;
                if (rd_sel_q <= SEL_SLEEP) begin
                    // Every mode shows the same range bit
                    s_axi_rdata[`BSS_CODE_W-1:0] <= {range_q, bank_rd_w};
                end else if (rd_sel_q == SEL_MODE) begin
                    s_axi_rdata[`BSS_MODE_W-1:0] <= mode_sw_q;
                end else if (rd_sel_q == SEL_STATUS) begin
                    s_axi_rdata[`BSS_CODE_W-1:0] <= target_code_o;
                    s_axi_rdata[`BSS_STAT_MODE_LSB +: `BSS_MODE_W] <=
                        mode_eff_w;
                    s_axi_rdata[`BSS_STAT_UNSUP_BIT] <= target_unsupported_o;
                end else begin
                    s_axi_rresp <= `BSS_RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Active target code and its voltage
    reg  [`BSS_SP_MSB:0]   act_sp_w;
    wire [`BSS_MV_W-1:0]   map_mv_w;
    wire                   map_bad_w;
    reg  [`BSS_CODE_W-1:0] code_q;

    always @* begin
        case (mode_eff_w)
            `BSS_MODE_STBY:  act_sp_w = bank_all_w[1*`BSS_SP_W +: `BSS_SP_W];
            `BSS_MODE_SLEEP: act_sp_w = bank_all_w[2*`BSS_SP_W +: `BSS_SP_W];
            default:         act_sp_w = bank_all_w[0 +: `BSS_SP_W];
        endcase
    end

    always @(posedge core_clk_i) begin
        if (srst_i) begin
            code_q        <= {`BSS_CODE_W{1'b0}};
            target_code_o <= {`BSS_CODE_W{1'b0}};
        end else begin
            code_q        <= {range_q, act_sp_w};
            target_code_o <= code_q;
        end
    end

    bss_code_map u_map (
        .core_clk_i    (core_clk_i),
        .srst_i        (srst_i),
        .code_i        (code_q),
        .mv_o          (map_mv_w),
        .unsupported_o (map_bad_w)
    );

    always @(posedge core_clk_i) begin
        if (srst_i) begin
            target_mv_o          <= `BSS_LO_BASE_MV;
            target_unsupported_o <= 1'b1;
        end else begin
            target_mv_o          <= map_mv_w;
            target_unsupported_o <= map_bad_w;
        end
    end

endmodule // bss_top

`default_nettype wire

/* File: dv/bss_top_assertions.sv */
// Port checker for bss_top: AXI answer timing and target outputs.
// Assumes bind into bss_top, one clock, sync active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "bss_defines.vh"
module bss_top_assertions (
    input wire logic        core_clk_i,
    input wire logic        srst_i,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [6:0]  target_code_o,
    input wire logic [11:0] target_mv_o,
    input wire logic        target_unsupported_o
);
default clocking cb @(posedge core_clk_i); endclocking
default disable iff (srst_i);
// Cycles since reset release, saturating; keeps $past off reset values
logic [3:0] up_q;
always_ff @(posedge core_clk_i)
    if (srst_i) up_q <= 4'h0;
    else if (up_q != 4'hF) up_q <= up_q + 4'h1;
function automatic logic [11:0] mv_of(input logic [6:0] c);
    return c[6] ? 12'h320 + c[5:0] * 12'h032 : 12'h190 + c[5:0] * 12'h019;
endfunction
////////////////////////////////////////////////////////////////////////////
property p_mv_map;
    (up_q > 4'h2) |-> target_mv_o == mv_of($past(target_code_o));
endproperty
a_mv_map: assert property (p_mv_map)
    else $error("voltage does not match target code");
property p_unsup;
    target_unsupported_o == (target_mv_o <= 12'h258);
endproperty
a_unsup: assert property (p_unsup)
    else $error("unsupported flag wrong for voltage");
property p_range_ro;
    (up_q > 4'h8) |-> $stable(target_code_o[6]);
endproperty
a_range_ro: assert property (p_range_ro)
    else $error("range bit changed after start-up");
property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
endproperty
a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
endproperty
a_r_hold: assert property (p_r_hold)
    else $error("read data dropped early");
property p_r_lat;
    s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid;
endproperty
a_r_lat: assert property (p_r_lat)
    else $error("read answer not two cycles after address");
property p_r_err;
    s_axi_rvalid && s_axi_rresp == `BSS_RESP_SLVERR |-> s_axi_rdata == 32'h0;
endproperty
a_r_err: assert property (p_r_err)
    else $error("refused read returned data");
property p_b_rise;
    $rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready;
endproperty
a_b_rise: assert property (p_b_rise)
    else $error("write answered while still accepting");
endmodule // bss_top_assertions
bind bss_top bss_top_assertions u_chk (.core_clk_i(core_clk_i),
    .srst_i(srst_i), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .target_code_o(target_code_o), .target_mv_o(target_mv_o),
    .target_unsupported_o(target_unsupported_o));
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench for bss_top over AXI4-Lite and the mode pins.
// Assumes the checker is bound in; strap changes only between resets.
`timescale 1ns/1ps
`default_nettype none
`include "bss_defines.vh"
module tb;
localparam logic [1:0] OK = `BSS_RESP_OKAY;
localparam logic [1:0] ER = `BSS_RESP_SLVERR;
logic        clk = 1'b0, srst = 1'b1, strap = 1'b0, men = 1'b0, r;
logic [1:0]  mpin = 2'h0, bresp, rresp;
logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
logic [3:0]  wstrb = 4'hF;
logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
logic        awready, wready, bvalid, arready, rvalid, unsup;
logic [6:0]  code;
logic [11:0] mv;
int          n_fail = 0, compares = 0, seed = 16;
logic [1:0]  exp_b[$];
logic [33:0] exp_r[$];
logic [5:0]  sp[3];
logic [5:0]  bnd[2][5] = '{'{6'h09, 6'h3F, 6'h0A, 6'h10, 6'h20},
                           '{6'h18, 6'h32, 6'h19, 6'h31, 6'h20}};
always #25 clk = ~clk;
bss_top uut (.core_clk_i(clk), .srst_i(srst), .range_strap_i(strap),
    .mode_pin_i(mpin), .mode_pin_en_i(men), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .target_code_o(code),
    .target_mv_o(mv), .target_unsupported_o(unsup));
////////////////////////////////////////////////////////////////////////////
task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    compares++;
    if (g !== e) begin
        n_fail++;
        $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
endtask
// Codes software may program: above 0.6 V; high range only 2.000 V..3.300 V
function automatic logic [5:0] pick(input logic hi, input logic [31:0] x);
    if (hi) return 6'(32'h18 + x % 32'h1B);
    return 6'(32'h09 + x % 32'h37);
endfunction
task automatic final_report();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
        $display("verification passed");
    else
        $display("verification failed");
    $finish;
endtask
task automatic tmo();
    n_fail++;
    $display("[ERR] handshake expected answer seen none");
    final_report();
endtask
// Handshakes are judged at the falling edge: inputs only move at rising
// edges, so these values are what the next rising edge will sample
// Response ready is held back 0..3 cycles at random so the slave must
// hold its answer
task automatic wr(input logic [31:0] a, input logic [31:0] d,
                  input logic [3:0] s, input logic [1:0] e);
    logic ah, wh, bh;
    int   dly;
    dly = {$random(seed)} % 4;
    exp_b.push_back(e);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (dly == 0);
    repeat (50) begin
        @(negedge clk);
        ah = awvalid && awready;
        wh = wvalid && wready;
        bh = bvalid && bready;
        @(posedge clk);
        if (ah) awvalid <= 1'b0;
        if (wh) wvalid <= 1'b0;
        if (bh) begin
            bready <= 1'b0;
            return;
        end
        if (dly > 0) dly--;
        if (dly == 0) bready <= 1'b1;
    end
    tmo();
endtask
task automatic rd(input logic [31:0] a, input logic [31:0] d,
                  input logic [1:0] e);
    logic ah, rh;
    int   dly;
    dly = {$random(seed)} % 4;
    exp_r.push_back({e, d});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (dly == 0);
    repeat (50) begin
        @(negedge clk);
        ah = arvalid && arready;
        rh = rvalid && rready;
        @(posedge clk);
        if (ah) arvalid <= 1'b0;
        if (rh) begin
            rready <= 1'b0;
            return;
        end
        if (dly > 0) dly--;
        if (dly == 0) rready <= 1'b1;
    end
    tmo();
endtask
always @(posedge clk) begin
    if (bvalid && bready) chk("bresp", exp_b.pop_front(), bresp);
    if (rvalid && rready) chk("rdata", exp_r.pop_front(), {rresp, rdata});
end
// Settle covers pin sync and filtering plus the output latencies
task automatic chk_out(input int i, input logic [1:0] m);
    logic [6:0]  c;
    logic [11:0] v;
    c = {r, sp[i]};
    v = r ? 12'h320 + sp[i] * 12'h032 : 12'h190 + sp[i] * 12'h019;
    repeat (10) @(posedge clk);
    chk("code", c, code);
    chk("mv", v, mv);
    chk("unsup", v <= 12'h258, unsup);
    rd(32'hE4, {v <= 12'h258, 6'h0, m, 1'b0, c}, OK);
endtask
////////////////////////////////////////////////////////////////////////////
initial begin
    for (int k = 0; k < 2; k++) begin
        srst <= 1'b1;
        strap <= k[0];
        men <= 1'b0;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        r = k[0];
        sp = '{default: 6'h00};
        repeat (5) @(posedge clk);
        chk_out(0, 2'h0);
        for (int i = 0; i < 3; i++) rd(32'hD4 + 4 * i, {r, 6'h00}, OK);
        for (int j = 0; j < 5; j++) begin
            sp[0] = bnd[k][j];
            wr(32'hD4, {26'h0, bnd[k][j]}, 4'hF, OK);
            chk_out(0, 2'h0);
        end
        // Bit 6 written inverted must not move the range
        for (int i = 0; i < 3; i++) begin
            sp[i] = pick(r, $random(seed));
            wr(32'hD4 + 4 * i, {25'h0, ~r, sp[i]}, 4'hF, OK);
        end
        for (int i = 0; i < 3; i++) rd(32'hD4 + 4 * i, {r, sp[i]}, OK);
        wr(32'hD4, 32'h3F, 4'hE, OK);
        wr(32'hE8, 32'h1, 4'hF, ER);
        wr(32'hD5, 32'h1, 4'hF, ER);
        rd(32'hD0, 32'h0, ER);
        rd(32'hD4, {r, sp[0]}, OK);
        for (int m = 0; m < 4; m++) begin
            wr(32'hE0, m, 4'hF, OK);
            rd(32'hE0, m, OK);
            chk_out(m == 3 ? 0 : m, 2'(m));
        end
        men <= 1'b1;
        for (int m = 3; m >= 0; m--) begin
            mpin <= 2'(m);
            chk_out(m == 3 ? 0 : m, 2'(m));
        end
        $display("range %0d tests done", k);
    end
    final_report();
end
endmodule // tb
`default_nettype wire
